/* pkg/qepu_regs.svh */
`ifndef QEPU_REGS_SVH
`define QEPU_REGS_SVH
// register byte offsets
`define QEPU_CONF_OFS 12'h000
`define QEPU_CONST_OFS 12'h004
`define QEPU_XENC_OFS 12'h008
`define QEPU_STATUS_OFS 12'h00c
`define QEPU_ILATCH_OFS 12'h010
`define QEPU_RLATCH_OFS 12'h014
`define QEPU_WARN_OFS 12'h018
`define QEPU_ERR_OFS 12'h01c
`define QEPU_VANGLE_OFS 12'h020
`define QEPU_VSCALE_OFS 12'h024
`define QEPU_LDLIM_OFS 12'h028
`define QEPU_USADR_OFS 12'h02c
// configuration field positions
`define QEPU_CONF_APOL 0
`define QEPU_CONF_BPOL 1
`define QEPU_CONF_NPOL 2
`define QEPU_CONF_NCLR 3
`define QEPU_CONF_NONCE 4
`define QEPU_CONF_DEC 5
`define QEPU_CONF_PIDEN 6
// status field positions
`define QEPU_ST_AEV 0
`define QEPU_ST_BEV 1
`define QEPU_ST_NEV 2
`define QEPU_ST_REV 3
`define QEPU_ST_WARN 4
// reset values
`define QEPU_CONF_RST 32'h0000_0000
`define QEPU_CONST_RST 32'h0001_0000
`define QEPU_WARN_RST 32'h7fff_ffff
`define QEPU_LDLIM_RST 32'h0000_0100
// decimal mode: one fraction unit in ten-thousandths
`define QEPU_DEC_BASE 32'd10000
`endif

/* pkg/qepu_pkg.sv */
`default_nettype none
package qepu_pkg;
	typedef enum logic [1:0] {
		QEPU_STEP_NONE = 2'b00,
		QEPU_STEP_UP = 2'b01,
		QEPU_STEP_DOWN = 2'b10
	} qepu_step_t;
endpackage : qepu_pkg
`default_nettype wire

/* core/qepu_sync.sv */
`timescale 1ns/100ps
`default_nettype none
// three-stage synchroniser; change accepted when stages two and three agree
module qepu_sync #(
	parameter int W = 4
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// pins and filtered levels
	input wire logic [W-1:0] pin_in,
	output logic [W-1:0] level_out
);
	logic [W-1:0] s1_r, s2_r, s3_r, lv_r;
	logic [W-1:0] lv_nxt;

	// only agreeing stages update the level, stage one feeds stage two only
	always_comb begin
		lv_nxt = lv_r;
		for (int i = 0; i < W; i++) begin
			if (s2_r[i] == s3_r[i]) begin
				lv_nxt[i] = s3_r[i];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1_r <= '0;
			s2_r <= '0;
			s3_r <= '0;
			lv_r <= '0;
		end else begin
			s1_r <= pin_in;
			s2_r <= s1_r;
			s3_r <= s2_r;
			lv_r <= lv_nxt;
		end
	end

	assign level_out = lv_r;
endmodule : qepu_sync
`default_nettype wire

/* core/qepu_top.sv */
`timescale 1ns/100ps
`default_nettype none
`include "qepu_regs.svh"
module qepu_top
	import qepu_pkg::*;
#(
	parameter int AW = 12
) (
	// apb clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// encoder and reference pins
	input wire logic enc_a,
	input wire logic enc_b,
	input wire logic enc_n,
	input wire logic ref_sw,
	// sequencer side
	input wire logic [31:0] x_actual,
	input wire logic [9:0] microstep_adr_in,
	output logic [31:0] pid_error,
	output logic [31:0] vector_encoder_angle,
	output logic [31:0] vector_encoder_scale,
	output logic [31:0] load_angle_limit,
	output logic [9:0] microstep_adr,
	output logic warn_irq
);
	// synchronised pin levels
	logic [3:0] lv;
	qepu_sync #(.W(4)) u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.pin_in({ref_sw, enc_n, enc_b, enc_a}),
		.level_out(lv)
	);

	// register state
	logic [31:0] conf_r, const_r, xenc_r, ilatch_r, rlatch_r, warn_r, err_r;
	logic [31:0] vangle_r, vscale_r, ldlim_r, prdata_r;
	logic [15:0] frac_r;
	logic [4:0] status_r;
	logic [3:0] lvp_r;
	logic nseen_r, pready_r, pslverr_r, irq_r;
	logic [9:0] usadr_r;
	logic [31:0] conf_nxt, const_nxt, xenc_nxt, ilatch_nxt, rlatch_nxt, warn_nxt, err_nxt;
	logic [31:0] vangle_nxt, vscale_nxt, ldlim_nxt, prdata_nxt;
	logic [15:0] frac_nxt;
	logic [4:0] status_nxt;
	logic nseen_nxt, pready_nxt, pslverr_nxt;
	logic [9:0] usadr_nxt;

	// absolute value of a signed word, used for the error before it is compared with warn_r
	function automatic logic [31:0] qepu_abs(input logic [31:0] v);
		qepu_abs = v[31] ? (~v + 32'h0000_0001) : v;
	endfunction : qepu_abs

	// polarity-corrected encoder levels; the reference switch level is used uncorrected
	logic a_i, b_i, n_i, ap_i, bp_i, np_i, n_rise, r_rise;
	assign a_i = lv[0] ^ conf_r[`QEPU_CONF_APOL];
	assign b_i = lv[1] ^ conf_r[`QEPU_CONF_BPOL];
	assign n_i = lv[2] ^ conf_r[`QEPU_CONF_NPOL];
	assign ap_i = lvp_r[0] ^ conf_r[`QEPU_CONF_APOL];
	assign bp_i = lvp_r[1] ^ conf_r[`QEPU_CONF_BPOL];
	assign np_i = lvp_r[2] ^ conf_r[`QEPU_CONF_NPOL];
	assign n_rise = n_i & ~np_i;
	assign r_rise = lv[3] & ~lvp_r[3];

	// quadrature decode; both samples see the same polarity bits, so a
	// polarity write alone never looks like a step
	qepu_step_t step;
	always_comb begin
		step = QEPU_STEP_NONE;
		if ((a_i != ap_i) && (b_i == bp_i)) begin
			step = (a_i != b_i) ? QEPU_STEP_UP : QEPU_STEP_DOWN;
		end else if ((b_i != bp_i) && (a_i == ap_i)) begin
			step = (a_i == b_i) ? QEPU_STEP_UP : QEPU_STEP_DOWN;
		end
	end

	// bus decode
	logic wr_acc, rd_acc;
	assign wr_acc = psel & penable & pwrite & ~pready_r;
	assign rd_acc = psel & penable & ~pwrite & ~pready_r;

	// position arithmetic: integer part plus fraction with carry
	logic [31:0] inc_int;
	logic [16:0] fsum;
	logic [15:0] fconst;
	logic [16:0] fmod;
	logic dec_mode;
	always_comb begin
		dec_mode = conf_r[`QEPU_CONF_DEC];
		fconst = const_r[15:0];
		if (dec_mode && fconst > 16'd9999) begin
			fconst = 16'd9999;
		end
		fmod = dec_mode ? 17'd10000 : 17'h10000;
		inc_int = {16'h0000, const_r[31:16]};
		fsum = 17'h00000;
		if (step == QEPU_STEP_UP) begin
			fsum = {1'b0, frac_r} + {1'b0, fconst};
			if (fsum >= fmod) begin
				fsum = fsum - fmod;
				inc_int = inc_int + 32'h0000_0001;
			end
		end else if (step == QEPU_STEP_DOWN) begin
			if ({1'b0, frac_r} >= {1'b0, fconst}) begin
				fsum = {1'b0, frac_r} - {1'b0, fconst};
			end else begin
				fsum = {1'b0, frac_r} + fmod - {1'b0, fconst};
				inc_int = inc_int + 32'h0000_0001;
			end
		end
	end

	// main next-state logic
	logic clr_idx, dev_over;
	logic [31:0] err_now;
	always_comb begin
		conf_nxt = conf_r;
		const_nxt = const_r;
		warn_nxt = warn_r;
		vangle_nxt = vangle_r;
		vscale_nxt = vscale_r;
		ldlim_nxt = ldlim_r;
		usadr_nxt = microstep_adr_in;
		ilatch_nxt = ilatch_r;
		rlatch_nxt = rlatch_r;
		status_nxt = status_r;
		nseen_nxt = nseen_r;
		xenc_nxt = xenc_r;
		frac_nxt = frac_r;
		// quadrature step
		if (step == QEPU_STEP_UP) begin
			xenc_nxt = xenc_r + inc_int;
			frac_nxt = fsum[15:0];
		end else if (step == QEPU_STEP_DOWN) begin
			xenc_nxt = xenc_r - inc_int;
			frac_nxt = fsum[15:0];
		end
		// index handling
		clr_idx = n_rise & conf_r[`QEPU_CONF_NCLR] &
			~(conf_r[`QEPU_CONF_NONCE] & nseen_r);
		if (n_rise) begin
			ilatch_nxt = xenc_r;
			nseen_nxt = 1'b1;
		end
		if (clr_idx) begin
			xenc_nxt = 32'h0000_0000;
			frac_nxt = 16'h0000;
		end
		if (r_rise) begin
			rlatch_nxt = xenc_r;
		end
		// deviation check
		err_now = xenc_r - x_actual;
		dev_over = conf_r[`QEPU_CONF_PIDEN] & (qepu_abs(err_r) > warn_r);
		err_nxt = conf_r[`QEPU_CONF_PIDEN] ? err_now : err_r;
		// software writes; write-one-to-clear on status
		if (wr_acc) begin
			case (paddr)
				`QEPU_CONF_OFS: begin
					conf_nxt = pwdata;
					if (pwdata[`QEPU_CONF_NONCE] && !conf_r[`QEPU_CONF_NONCE]) begin
						nseen_nxt = 1'b0; // arming re-enables the first clear
					end
				end
				`QEPU_CONST_OFS: const_nxt = pwdata;
				`QEPU_XENC_OFS: begin
					xenc_nxt = pwdata;
					frac_nxt = 16'h0000;
				end
				`QEPU_STATUS_OFS: status_nxt = status_r & ~pwdata[4:0];
				`QEPU_WARN_OFS: warn_nxt = pwdata;
				`QEPU_VANGLE_OFS: vangle_nxt = pwdata;
				`QEPU_VSCALE_OFS: vscale_nxt = pwdata;
				`QEPU_LDLIM_OFS: ldlim_nxt = pwdata;
				default: ;
			endcase
		end
		// hardware events win over a same-cycle clear
		if (a_i != ap_i) status_nxt[`QEPU_ST_AEV] = 1'b1;
		if (b_i != bp_i) status_nxt[`QEPU_ST_BEV] = 1'b1;
		if (n_rise) status_nxt[`QEPU_ST_NEV] = 1'b1;
		if (r_rise) status_nxt[`QEPU_ST_REV] = 1'b1;
		if (dev_over) status_nxt[`QEPU_ST_WARN] = 1'b1;
	end

	// apb answer: one wait state, ready in the cycle after the access phase starts
	always_comb begin
		prdata_nxt = 32'h0000_0000;
		pslverr_nxt = 1'b0;
		pready_nxt = psel & penable & ~pready_r;
		if (rd_acc || wr_acc) begin
			case (paddr)
				`QEPU_CONF_OFS: prdata_nxt = conf_r;
				`QEPU_CONST_OFS: prdata_nxt = const_r;
				`QEPU_XENC_OFS: prdata_nxt = xenc_r;
				`QEPU_STATUS_OFS: prdata_nxt = {27'h0000000, status_r};
				`QEPU_ILATCH_OFS: prdata_nxt = ilatch_r;
				`QEPU_RLATCH_OFS: prdata_nxt = rlatch_r;
				`QEPU_WARN_OFS: prdata_nxt = warn_r;
				`QEPU_ERR_OFS: prdata_nxt = err_r;
				`QEPU_VANGLE_OFS: prdata_nxt = vangle_r;
				`QEPU_VSCALE_OFS: prdata_nxt = vscale_r;
				`QEPU_LDLIM_OFS: prdata_nxt = ldlim_r;
				`QEPU_USADR_OFS: prdata_nxt = {22'h000000, usadr_r};
				default: pslverr_nxt = 1'b1;
			endcase
			// a write answers with zero data
			if (pwrite) begin
				prdata_nxt = 32'h0000_0000;
			end
		end
	end

	// registers only
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			conf_r <= `QEPU_CONF_RST;
			const_r <= `QEPU_CONST_RST;
			xenc_r <= 32'h0000_0000;
			frac_r <= 16'h0000;
			ilatch_r <= 32'h0000_0000;
			rlatch_r <= 32'h0000_0000;
			warn_r <= `QEPU_WARN_RST;
			err_r <= 32'h0000_0000;
			vangle_r <= 32'h0000_0000;
			vscale_r <= 32'h0000_0000;
			ldlim_r <= `QEPU_LDLIM_RST;
			usadr_r <= 10'h000;
			status_r <= 5'h00;
			lvp_r <= 4'h0;
			nseen_r <= 1'b0;
			prdata_r <= 32'h0000_0000;
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			irq_r <= 1'b0;
		end else begin
			conf_r <= conf_nxt;
			const_r <= const_nxt;
			xenc_r <= xenc_nxt;
			frac_r <= frac_nxt;
			ilatch_r <= ilatch_nxt;
			rlatch_r <= rlatch_nxt;
			warn_r <= warn_nxt;
			err_r <= err_nxt;
			vangle_r <= vangle_nxt;
			vscale_r <= vscale_nxt;
			ldlim_r <= ldlim_nxt;
			usadr_r <= usadr_nxt;
			status_r <= status_nxt;
			lvp_r <= lv;
			nseen_r <= nseen_nxt;
			prdata_r <= prdata_nxt;
			pready_r <= pready_nxt;
			pslverr_r <= pslverr_nxt;
			irq_r <= status_nxt[`QEPU_ST_WARN];
		end
	end

	// outputs straight from flip-flops
	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign pid_error = err_r;
	assign vector_encoder_angle = vangle_r;
	assign vector_encoder_scale = vscale_r;
	assign load_angle_limit = ldlim_r;
	assign microstep_adr = usadr_r;
	assign warn_irq = irq_r;
endmodule : qepu_top
`default_nettype wire

/* verification/qepu_asserts.sv */
`timescale 1ns/100ps
`default_nettype none
`include "qepu_regs.svh"
module qepu_asserts #(
	parameter int AW = 12
) (
	// apb side
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// sequencer side
	input wire logic [9:0] microstep_adr_in,
	input wire logic [9:0] microstep_adr,
	input wire logic [31:0] vector_encoder_angle,
	input wire logic [31:0] load_angle_limit,
	input wire logic warn_irq
);
	logic wr_go;
	logic clr_go;
	// writes commit on the first access edge only
	assign wr_go = psel && penable && pwrite && !pready;
	assign clr_go = wr_go && paddr == `QEPU_STATUS_OFS && pwdata[`QEPU_ST_WARN];
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	ready_pulse_a:
	assert property (psel && penable && !pready |=> pready ##1 !pready)
		else $error("pready not one cycle after access");
	err_ready_a:
	assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	rdata_quiet_a:
	assert property (!pready |-> prdata == 32'h0)
		else $error("read data outside answer");
	angle_load_a:
	assert property (wr_go && paddr == `QEPU_VANGLE_OFS |=> vector_encoder_angle == $past(pwdata))
		else $error("vector angle not loaded");
	limit_load_a:
	assert property (wr_go && paddr == `QEPU_LDLIM_OFS |=> load_angle_limit == $past(pwdata))
		else $error("load limit not loaded");
	usadr_copy_a:
	assert property ($past(presetn) |-> microstep_adr == $past(microstep_adr_in))
		else $error("microstep address not copied");
	power_on_a:
	assert property ($rose(presetn) |-> microstep_adr == 10'h0 && load_angle_limit == 32'h100)
		else $error("wrong values after reset");
	warn_hold_a:
	assert property ($fell(warn_irq) |-> $past(clr_go) || $past(clr_go, 2) || $past(clr_go, 3))
		else $error("warning dropped without clear");
endmodule : qepu_asserts
bind qepu_top qepu_asserts #(.AW(AW)) u_asserts (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .microstep_adr_in(microstep_adr_in),
	.microstep_adr(microstep_adr), .vector_encoder_angle(vector_encoder_angle),
	.load_angle_limit(load_angle_limit), .warn_irq(warn_irq));
`default_nettype wire

/* verification/qepu_enc_model.sv */
`timescale 1ns/100ps
`default_nettype none
module qepu_enc_model (
	// clock
	input wire logic pclk,
	// encoder pins
	output logic enc_a,
	output logic enc_b,
	output logic enc_n
);
	logic [1:0] ph = 2'b00;
	logic [2:0] inv = 3'b000;
	logic n_on = 1'b0;
	// gray phase, so a single step moves one line only
	always_comb begin
		enc_a = ph[0] ^ ph[1] ^ inv[0];
		enc_b = ph[1] ^ inv[1];
		enc_n = n_on ^ inv[2];
	end
	// dual moves both lines in one edge, a fault the decoder must drop
	task automatic step(input logic up, input logic du, input int hold);
		@(posedge pclk);
		ph <= du ? ph + 2'd2 : (up ? ph + 2'd1 : ph - 2'd1);
		repeat (hold) @(posedge pclk);
	endtask : step
	// index pulse held long enough for the synchroniser
	task automatic index();
		@(posedge pclk);
		n_on <= 1'b1;
		repeat (4) @(posedge pclk);
		n_on <= 1'b0;
	endtask : index
endmodule : qepu_enc_model
`default_nettype wire

/* verification/tb.sv */
`timescale 1ns/100ps
`default_nettype none
`include "qepu_regs.svh"
module tb;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, ref_sw = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, x_actual = 32'h0, k, pos, rd_v, prdata, pid_error, vang, vsc, ldl;
	logic [9:0] us_in = 10'h0, us_out;
	logic [15:0] fr;
	logic pready, pslverr, enc_a, enc_b, enc_n, warn_irq, slv;
	int err_count = 0, checked = 0;
	qepu_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.enc_a(enc_a), .enc_b(enc_b), .enc_n(enc_n), .ref_sw(ref_sw), .x_actual(x_actual),
		.microstep_adr_in(us_in), .pid_error(pid_error), .vector_encoder_angle(vang),
		.vector_encoder_scale(vsc), .load_angle_limit(ldl), .microstep_adr(us_out),
		.warn_irq(warn_irq));
	qepu_enc_model enc (.pclk(pclk), .enc_a(enc_a), .enc_b(enc_b), .enc_n(enc_n));
	always #12.5 pclk = ~pclk;
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	// request held until pready is sampled high
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd_v = prdata;
		slv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rd_v, e);
	endtask : rd
	// expected step: integer count plus a hidden fraction that carries
	// at 2^16 in binary mode and at ten thousand in decimal mode
	function automatic void adv(input logic up, input logic dec);
		logic [16:0] md, kf, s;
		md = dec ? 17'h02710 : 17'h10000;
		kf = {1'b0, k[15:0]};
		if (dec && kf > 17'h0270f) kf = 17'h0270f;
		if (up) begin
			s = {1'b0, fr} + kf;
			pos = pos + {16'h0000, k[31:16]} + 32'(s >= md);
			if (s >= md) s = s - md;
		end else begin
			pos = pos - {16'h0000, k[31:16]} - 32'({1'b0, fr} < kf);
			s = ({1'b0, fr} < kf) ? {1'b0, fr} + md - kf : {1'b0, fr} - kf;
		end
		fr = s[15:0];
	endfunction : adv
	// in binary mode every fifth step moves both lines and must not count
	task automatic walk(input int n, input logic dec);
		logic up, du;
		for (int i = 0; i < n; i++) begin
			up = dec | 1'($urandom);
			du = !dec && i % 5 == 2;
			enc.step(up, du, $urandom_range(6, 3));
			if (!du) adv(up, dec);
		end
		repeat (8) @(posedge pclk);
	endtask : walk
	task automatic end_sim();
		$display("checks %0d errors %0d", checked, err_count);
		if (err_count == 0 && checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : end_sim
	// hang guard, far beyond the expected run
	initial begin
		repeat (30000) @(posedge pclk);
		err_count++;
		end_sim();
	end
	initial begin
		void'($urandom(89));
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		rd(`QEPU_CONST_OFS, 32'h0001_0000);
		rd(`QEPU_USADR_OFS, 32'h0);
		rd(12'h0fc, 32'h0);
		chk(32'(slv), 32'h1);
		k = $urandom & 32'h000f_ffff;
		{pos, fr} = 48'h0;
		apb(1'b1, `QEPU_CONST_OFS, k);
		walk(40, 1'b0);
		rd(`QEPU_XENC_OFS, pos);
		rd(`QEPU_STATUS_OFS, 32'h3);
		apb(1'b1, `QEPU_STATUS_OFS, 32'h1f);
		apb(1'b1, `QEPU_CONF_OFS, 32'h20);
		apb(1'b1, `QEPU_XENC_OFS, 32'h0);
		k = 32'h0002_1388;
		{pos, fr} = 48'h0;
		apb(1'b1, `QEPU_CONST_OFS, k);
		walk(3, 1'b1);
		rd(`QEPU_XENC_OFS, pos);
		// flip polarity first, then arm first-index clear so the flip is not counted
		k = 32'h0001_8000;
		apb(1'b1, `QEPU_CONST_OFS, k);
		apb(1'b1, `QEPU_CONF_OFS, 32'h0f);
		enc.inv <= 3'b111;
		repeat (8) @(posedge pclk);
		apb(1'b1, `QEPU_CONF_OFS, 32'h1f);
		apb(1'b1, `QEPU_XENC_OFS, 32'h0);
		{pos, fr} = 48'h0;
		walk(4, 1'b0);
		enc.index();
		repeat (8) @(posedge pclk);
		rd(`QEPU_ILATCH_OFS, pos);
		rd(`QEPU_XENC_OFS, 32'h0);
		{pos, fr} = 48'h0;
		walk(4, 1'b0);
		enc.index();
		ref_sw <= 1'b1;
		repeat (8) @(posedge pclk);
		ref_sw <= 1'b0;
		rd(`QEPU_XENC_OFS, pos);
		rd(`QEPU_RLATCH_OFS, pos);
		rd(`QEPU_STATUS_OFS, 32'hf);
		apb(1'b1, `QEPU_WARN_OFS, 32'h5);
		apb(1'b1, `QEPU_CONF_OFS, 32'h4f);
		x_actual <= pos - 32'ha;
		repeat (8) @(posedge pclk);
		chk(pid_error, 32'ha);
		chk(32'(warn_irq), 32'h1);
		x_actual <= pos + 32'h3;
		repeat (8) @(posedge pclk);
		chk(pid_error, 32'hffff_fffd);
		chk(32'(warn_irq), 32'h1);
		apb(1'b1, `QEPU_STATUS_OFS, 32'h1f);
		apb(1'b1, `QEPU_CONF_OFS, 32'h0f);
		x_actual <= pos + 32'h64;
		repeat (8) @(posedge pclk);
		chk(32'(warn_irq), 32'h0);
		chk(pid_error, 32'hffff_fffd);
		k = pos + 32'h0000_0123;
		apb(1'b1, `QEPU_VANGLE_OFS, k);
		chk(vang, k);
		apb(1'b1, `QEPU_VSCALE_OFS, 32'h0000_0640);
		chk(vsc, 32'h0000_0640);
		k = 32'h0000_0101 + ($urandom & 32'h0000_00ff);
		apb(1'b1, `QEPU_LDLIM_OFS, k);
		chk(ldl, k);
		us_in <= 10'($urandom);
		repeat (3) @(posedge pclk);
		chk(32'(us_out), 32'(us_in));
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		chk(32'(us_out), 32'h0);
		chk(ldl, `QEPU_LDLIM_RST);
		presetn <= 1'b1;
		rd(`QEPU_XENC_OFS, 32'h0);
		end_sim();
	end
endmodule : tb
`default_nettype wire
